// >>> byte_cursor.sv
// Table byte cursor that loads and steps by one.
`timescale 1ns/100ps
module byte_cursor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [23:0] load_val,
  input wire logic step,
  output logic [23:0] addr_ff
);

  logic [23:0] nxt_addr;

  // A load wins over a step in the same cycle; the cursor wraps at the top.
  assign nxt_addr = load ? load_val : (step ? addr_ff + 24'h1 : addr_ff);

  // Cursor register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_ff <= param_rom_pkg::CURSOR_RESET;
    end else begin
      addr_ff <= nxt_addr;
    end
  end

endmodule : byte_cursor

// >>> flash_host_model.sv
// Host controller model that fetches table bytes over the register bus.
`timescale 1ns/100ps
module flash_host_model (
  input wire logic aclk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready,
  output logic hung
);
  // All requests start idle so nothing is offered during reset.
  initial begin
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    hung = 1'b0;
    awaddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    araddr = 12'h000;
  end

  // Fetches one word by byte address and holds it until taken.
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 1000);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 1000);
    if (n >= 1000) hung = 1'b1;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // Offers address and data together; the answer follows both.
  task automatic wr(input logic [11:0] a, input logic [31:0] v,
                    input logic [3:0] s, output logic [1:0] r);
    int n;
    logic aw_done;
    logic w_done;
    n = 0;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready) aw_done = 1'b1;
      if (!w_done && wready) w_done = 1'b1;
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end while (!(aw_done && w_done) && n < 1000);
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 1000);
    if (n >= 1000) hung = 1'b1;
    r = bresp;
    bready <= 1'b0;
  endtask : wr
endmodule : flash_host_model

// >>> param_rom_lookup.sv
// Fixed byte lookup of the parameter table slice.
`timescale 1ns/100ps
module param_rom_lookup #(
  parameter logic [7:0] maker_code = 8'h5A // Arbitrary value.
) (
  input wire logic [23:0] byte_addr,
  output logic [7:0] data,
  output logic hit
);

  logic [7:0] caps_byte;

  // Capability byte built from its fields; unused bits are tied high.
  assign caps_byte = {param_rom_pkg::UNUSED_ONES, // R12
                      param_rom_pkg::WREN_06_SELECT, // R11
                      param_rom_pkg::VOLATILE_STAT, // R10
                      param_rom_pkg::BUFFERED_PROG, // R9
                      param_rom_pkg::ERASE_4K_YES}; // R8

  // Contents are constants; nothing can write them.
  always_comb begin
    hit = 1'b1;
    case (byte_addr)
      param_rom_pkg::SECMAP_LEN_ADR: data = param_rom_pkg::SECMAP_LEN; // R1
      param_rom_pkg::SECMAP_PTR_ADR:
        data = param_rom_pkg::SECMAP_PTR[7:0]; // R2 R3
      param_rom_pkg::SECMAP_PTR_ADR + 24'h1:
        data = param_rom_pkg::SECMAP_PTR[15:8]; // R2
      param_rom_pkg::SECMAP_PTR_ADR + 24'h2:
        data = param_rom_pkg::SECMAP_PTR[23:16]; // R2
      param_rom_pkg::SECMAP_IDMSB_ADR: data = param_rom_pkg::SECMAP_IDMSB;
      param_rom_pkg::VEND_ID_ADR: data = maker_code; // R4
      param_rom_pkg::VEND_MINOR_ADR: data = param_rom_pkg::VEND_MINOR; // R5
      param_rom_pkg::VEND_MAJOR_ADR: data = param_rom_pkg::VEND_MAJOR; // R5
      param_rom_pkg::VEND_LEN_ADR: data = param_rom_pkg::VEND_LEN; // R6
      param_rom_pkg::VEND_PTR_ADR:
        data = param_rom_pkg::VEND_PTR[7:0]; // R2 R3
      param_rom_pkg::VEND_PTR_ADR + 24'h1:
        data = param_rom_pkg::VEND_PTR[15:8]; // R2
      param_rom_pkg::VEND_PTR_ADR + 24'h2:
        data = param_rom_pkg::VEND_PTR[23:16]; // R2
      param_rom_pkg::VEND_BANK_ADR: data = param_rom_pkg::VEND_BANK; // R7
      param_rom_pkg::ERASE_CAPS_ADR: data = caps_byte; // R8
      param_rom_pkg::ERASE_OP_ADR: data = param_rom_pkg::ERASE_OP; // R8
      default: begin
        data = param_rom_pkg::FILL_BYTE;
        hit = 1'b0;
      end
    endcase
  end

endmodule : param_rom_lookup

// >>> param_rom_pkg.sv
// Constants, address map and carrier types for the parameter table slice.
package param_rom_pkg;

  // Table byte addresses covered by this slice.
  localparam logic [23:0] SECMAP_LEN_ADR = 24'h00_0013;
  localparam logic [23:0] SECMAP_PTR_ADR = 24'h00_0014;
  localparam logic [23:0] SECMAP_IDMSB_ADR = 24'h00_0017;
  localparam logic [23:0] VEND_ID_ADR = 24'h00_0018;
  localparam logic [23:0] VEND_MINOR_ADR = 24'h00_0019;
  localparam logic [23:0] VEND_MAJOR_ADR = 24'h00_001A;
  localparam logic [23:0] VEND_LEN_ADR = 24'h00_001B;
  localparam logic [23:0] VEND_PTR_ADR = 24'h00_001C;
  localparam logic [23:0] VEND_BANK_ADR = 24'h00_001F;
  localparam logic [23:0] ERASE_CAPS_ADR = 24'h00_0030;
  localparam logic [23:0] ERASE_OP_ADR = 24'h00_0031;

  // Table contents.
  localparam logic [7:0] SECMAP_LEN = 8'h06;
  localparam logic [23:0] SECMAP_PTR = 24'h00_0100;
  localparam logic [7:0] SECMAP_IDMSB = 8'hFF;
  localparam logic [7:0] VEND_MINOR = 8'h00;
  localparam logic [7:0] VEND_MAJOR = 8'h01;
  localparam logic [7:0] VEND_LEN = 8'h18;
  localparam logic [23:0] VEND_PTR = 24'h00_0200;
  localparam logic [7:0] VEND_BANK = 8'h01;
  localparam logic [7:0] ERASE_OP = 8'h20;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // Fields of the erase and write capability byte.
  localparam logic [1:0] ERASE_4K_YES = 2'h1;
  localparam logic [1:0] ERASE_4K_NO = 2'h3;
  localparam logic BUFFERED_PROG = 1'b1;
  localparam logic VOLATILE_STAT = 1'b1;
  localparam logic WREN_06_SELECT = 1'b1;
  localparam logic [2:0] UNUSED_ONES = 3'h7;
  localparam int ERASE_FLD_LSB = 0;
  localparam int GRAN_BIT = 2;
  localparam int VOLAT_BIT = 3;
  localparam int WREN_BIT = 4;
  localparam int UNUSED_LSB = 5;

  // Bus map: table byte N sits at byte address 4*N below TABLE_TOP.
  localparam logic [11:0] TABLE_TOP = 12'h400;
  localparam logic [11:0] CURSOR_ADR = 12'h400;
  localparam logic [11:0] STREAM_ADR = 12'h404;
  localparam int HIT_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [23:0] CURSOR_RESET = 24'h00_0000;

  // Read answer carried together.
  typedef struct packed {
    logic [1:0] resp;
    logic [31:0] data;
  } rd_ans_type;

  typedef enum logic [0:0] {WR_COLLECT, WR_ANSWER} wr_state_type;

endpackage : param_rom_pkg

// >>> param_rom_slice.sv
// Parameter table slice reached over an AXI4-Lite slave port.
//
// How it works
// R1: byte 13H returns sector-map table length 06H.
// R2: table pointers low byte first, 000100H, 000200H.
// R3: every returned pointer is word aligned.
// R4: byte 18H holds the maker identification code.
// R5: vendor header revision 1.0 at 19H, 1AH.
// R6: byte 1BH returns vendor table length 18H.
// R7: byte 1FH returns bank number 01H.
// R8: byte 30H is FDH; 31H gives opcode 20H.
// R9: bit 2 of 30H: buffered programming.
// R10: bit 3 of 30H: volatile status bits.
// R11: bit 4 of 30H: write enable 06H.
// R12: bits 7:5 of 30H read 111b, unwritable.
// R13: bytes read from address, successive, never writable.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module param_rom_slice #(
  parameter logic [7:0] maker_code = 8'h5A // Arbitrary value.
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [11:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  param_rom_pkg::wr_state_type wr_state_ff;
  param_rom_pkg::wr_state_type nxt_wr_state;

  logic aw_hs;
  logic w_hs;
  logic b_hs;
  logic ar_hs;
  logic r_hs;
  logic aw_held;
  logic w_held;
  logic wr_commit;
  logic wr_cursor;
  logic rd_table;
  logic rd_cursor;
  logic rd_stream;
  logic [23:0] cursor_ff;
  logic [23:0] cursor_load_val;
  logic [23:0] direct_addr;
  logic [7:0] direct_data;
  logic direct_hit;
  logic [7:0] stream_data;
  logic stream_hit;
  logic [1:0] wr_resp;
  param_rom_pkg::rd_ans_type rd_ans;

  // Handshakes of the five channels.
  assign aw_hs = s_axi_awvalid & awready_ff;
  assign w_hs = s_axi_wvalid & wready_ff;
  assign b_hs = bvalid_ff & s_axi_bready;
  assign ar_hs = s_axi_arvalid & arready_ff;
  assign r_hs = rvalid_ff & s_axi_rready;

  // Address and data are held once ready has dropped after their handshake.
  // Ready stays low until the answer is taken, so one write is open at once.
  assign aw_held = !awready_ff;
  assign w_held = !wready_ff;
  assign wr_commit = (wr_state_ff == param_rom_pkg::WR_COLLECT) &&
                     aw_held && w_held;

  // Only the cursor is writable; table bytes refuse every write.
  assign wr_cursor = wr_commit && (awaddr_ff == param_rom_pkg::CURSOR_ADR);
  assign wr_resp = (awaddr_ff == param_rom_pkg::CURSOR_ADR) ?
                   param_rom_pkg::RESP_OKAY :
                   param_rom_pkg::RESP_SLVERR; // R13
  assign cursor_load_val = {wstrb_ff[2] ? wdata_ff[23:16] : cursor_ff[23:16],
                            wstrb_ff[1] ? wdata_ff[15:8] : cursor_ff[15:8],
                            wstrb_ff[0] ? wdata_ff[7:0] : cursor_ff[7:0]};

  // Read decode: table bytes at four times their byte address.
  assign rd_table = (s_axi_araddr < param_rom_pkg::TABLE_TOP) &&
                    (s_axi_araddr[1:0] == 2'h0);
  assign rd_cursor = (s_axi_araddr == param_rom_pkg::CURSOR_ADR);
  assign rd_stream = (s_axi_araddr == param_rom_pkg::STREAM_ADR);
  assign direct_addr = {14'h0000, s_axi_araddr[11:2]};

  // Direct lookup of one table byte by bus address.
  param_rom_lookup #(.maker_code(maker_code)) direct_rom (
    .byte_addr(direct_addr),
    .data(direct_data),
    .hit(direct_hit)
  );

  // Lookup of the byte under the cursor for sequential reads.
  param_rom_lookup #(.maker_code(maker_code)) stream_rom (
    .byte_addr(cursor_ff),
    .data(stream_data),
    .hit(stream_hit)
  );

  // Each stream read takes one byte and advances to the next, except when a cursor write loads the cursor in the same cycle.
  byte_cursor cursor (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(wr_cursor),
    .load_val(cursor_load_val),
    .step(ar_hs && rd_stream), // R13
    .addr_ff(cursor_ff)
  );

  // Read answer selection.
  always_comb begin
    rd_ans.resp = param_rom_pkg::RESP_OKAY;
    rd_ans.data = 32'h0000_0000;
    if (rd_table && direct_hit) begin
      rd_ans.data = {24'h00_0000, direct_data};
    end else if (rd_cursor) begin
      rd_ans.data = {8'h00, cursor_ff};
    end else if (rd_stream) begin
      rd_ans.data = {23'h00_0000, stream_hit, stream_data}; // R13
    end else begin
      rd_ans.resp = param_rom_pkg::RESP_SLVERR;
    end
  end

  // Write response state.
  always_comb begin
    nxt_wr_state = wr_state_ff;
    case (wr_state_ff)
      param_rom_pkg::WR_COLLECT: begin
        if (wr_commit) begin
          nxt_wr_state = param_rom_pkg::WR_ANSWER;
        end
      end
      param_rom_pkg::WR_ANSWER: begin
        if (b_hs) begin
          nxt_wr_state = param_rom_pkg::WR_COLLECT;
        end
      end
      default: nxt_wr_state = param_rom_pkg::WR_COLLECT;
    endcase
  end

  // Write channels: address and data taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= param_rom_pkg::WR_COLLECT;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= param_rom_pkg::RESP_OKAY;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      wr_state_ff <= nxt_wr_state;
      if (aw_hs) begin
        awaddr_ff <= s_axi_awaddr;
        awready_ff <= 1'b0;
      end else if (b_hs) begin
        awready_ff <= 1'b1;
      end
      if (w_hs) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        wready_ff <= 1'b0;
      end else if (b_hs) begin
        wready_ff <= 1'b1;
      end
      if (wr_commit) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_resp;
      end else if (b_hs) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // Read channels: answer one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= param_rom_pkg::RESP_OKAY;
    end else begin
      if (ar_hs) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_ans.data;
        rresp_ff <= rd_ans.resp;
      end else if (r_hs) begin
        arready_ff <= 1'b1;
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Checks on direct table read values, on table write refusal and on stream reads.
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_secmap_len: assert property ( // R1
    ar_hs && s_axi_araddr == 12'h04C |=> rvalid_ff && rdata_ff == 32'h06)
    else $error("Sector map length byte wrong.");
  chk_ptr_bytes: assert property ( // R2
    ar_hs && (s_axi_araddr == 12'h054 || s_axi_araddr == 12'h074)
    |=> rdata_ff == (($past(s_axi_araddr) == 12'h054) ? 32'h01 : 32'h02))
    else $error("Table pointer middle byte wrong.");
  chk_ptr_align: assert property ( // R3
    ar_hs && (s_axi_araddr == 12'h050 || s_axi_araddr == 12'h070)
    |=> rdata_ff[1:0] == 2'h0 && rresp_ff == param_rom_pkg::RESP_OKAY)
    else $error("Table pointer not word aligned.");
  chk_maker_code: assert property ( // R4
    ar_hs && s_axi_araddr == 12'h060 |=> rdata_ff[7:0] == maker_code)
    else $error("Maker code byte wrong.");
  chk_vend_rev: assert property ( // R5
    ar_hs && (s_axi_araddr == 12'h064 || s_axi_araddr == 12'h068)
    |=> rdata_ff == {31'h0, $past(s_axi_araddr[3])})
    else $error("Vendor revision wrong.");
  chk_vend_len: assert property ( // R6
    ar_hs && s_axi_araddr == 12'h06C |=> rdata_ff == 32'h18)
    else $error("Vendor table length wrong.");
  chk_bank_num: assert property ( // R7
    ar_hs && s_axi_araddr == 12'h07C |=> rdata_ff == 32'h01)
    else $error("Bank number wrong.");
  chk_erase_op: assert property ( // R8
    ar_hs && s_axi_araddr == 12'h0C4 |=> rdata_ff == 32'h20)
    else $error("Erase opcode wrong.");
  chk_erase_4k: assert property ( // R8
    ar_hs && s_axi_araddr == 12'h0C0
    |=> rdata_ff[param_rom_pkg::ERASE_FLD_LSB +: 2] == 2'h1)
    else $error("Erase size field wrong.");
  chk_buf_prog: assert property ( // R9
    ar_hs && s_axi_araddr == 12'h0C0 |=> rdata_ff[param_rom_pkg::GRAN_BIT])
    else $error("Buffered programming bit wrong.");
  chk_volatile_bit: assert property ( // R10
    ar_hs && s_axi_araddr == 12'h0C0 |=> rdata_ff[param_rom_pkg::VOLAT_BIT])
    else $error("Volatile status bit wrong.");
  chk_wren_select: assert property ( // R11
    ar_hs && s_axi_araddr == 12'h0C0 |=> rdata_ff[param_rom_pkg::WREN_BIT])
    else $error("Write enable select bit wrong.");
  chk_unused_ones: assert property ( // R12
    ar_hs && s_axi_araddr == 12'h0C0
    |=> rdata_ff[param_rom_pkg::UNUSED_LSB +: 3] == 3'h7)
    else $error("Unused capability bits not ones.");
  chk_table_wprot: assert property ( // R13
    wr_commit && awaddr_ff < param_rom_pkg::TABLE_TOP
    |=> bvalid_ff && bresp_ff == param_rom_pkg::RESP_SLVERR)
    else $error("Table write not refused.");
  chk_stream_step: assert property ( // R13
    ar_hs && rd_stream && !wr_cursor |=> cursor_ff == $past(cursor_ff) + 24'h1)
    else $error("Cursor did not advance.");
  chk_stream_miss: assert property ( // R13
    ar_hs && rd_stream && !stream_hit |=> rdata_ff == 32'h0000_00FF)
    else $error("Stream read outside slice wrong.");

  // Handshake timing that the bus master relies on; a slip here would
  // leave a request hanging or answer a read twice.
  chk_read_answer: assert property ( // R13
    ar_hs |=> rvalid_ff && !arready_ff)
    else $error("Read answer not one cycle after address.");
  chk_read_release: assert property ( // R13
    r_hs |=> !rvalid_ff && arready_ff)
    else $error("Read channel not released after answer.");
  chk_write_answer: assert property ( // R13
    wr_commit |=> bvalid_ff && wr_state_ff == param_rom_pkg::WR_ANSWER)
    else $error("Write answer missing after commit.");
  chk_write_release: assert property ( // R13
    b_hs |=> !bvalid_ff && awready_ff && wready_ff)
    else $error("Write channels not released after answer.");
  chk_cursor_okay: assert property ( // R13
    wr_cursor |=> bvalid_ff && bresp_ff == param_rom_pkg::RESP_OKAY)
    else $error("Cursor write refused.");

endmodule : param_rom_slice

// >>> test_param_rom_slice.sv
// Self-checking bench for the parameter table slice.
`timescale 1ns/100ps
module test_param_rom_slice;
  localparam logic [7:0] maker_val = 8'h3C; // Arbitrary value.
  logic aclk;
  logic aresetn;
  logic [11:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [11:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic hung;
  int errors = 0;
  int total_checks = 0;

  param_rom_slice #(.maker_code(maker_val)) param_rom_slice_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  flash_host_model flash_host_model_i (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hung(hung));

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  // Compares response and data together against the expected pair.
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bus read; a bus that never answers ends the run as a mismatch.
  task automatic fetch(input logic [11:0] a, output logic [33:0] got);
    logic [31:0] d;
    logic [1:0] r;
    flash_host_model_i.rd(a, d, r);
    got = {r, d};
    if (hung) begin
      errors++;
      $display("BAD %0t bus read hung", $time);
      end_sim();
    end
  endtask : fetch

  // Bus write with the same hang handling as the read.
  task automatic put(input logic [11:0] a, input logic [31:0] v,
                     input logic [3:0] s, output logic [33:0] got);
    logic [1:0] r;
    flash_host_model_i.wr(a, v, s, r);
    got = {r, 32'h0000_0000};
    if (hung) begin
      errors++;
      $display("BAD %0t bus write hung", $time);
      end_sim();
    end
  endtask : put

  // Reads the header bytes 13H to 1FH and checks pointer alignment.
  task automatic headers_scn();
    logic [7:0] hdr [0:12] = '{8'h06, 8'h00, 8'h01, 8'h00, 8'hFF, maker_val,
      8'h00, 8'h01, 8'h18, 8'h00, 8'h02, 8'h00, 8'h01};
    logic [7:0] got_b [0:12];
    logic [33:0] got;
    for (int i = 0; i < 13; i++) begin
      fetch(12'((8'h13 + i) * 4), got);
      got_b[i] = got[7:0];
      check(got, {2'h0, 24'h00_0000, hdr[i]});
    end
    check(34'({got_b[3], got_b[2], got_b[1]} & 24'h00_0003), 34'h0);
    check(34'({got_b[11], got_b[10], got_b[9]} & 24'h00_0003), 34'h0);
  endtask : headers_scn

  // Reads the capability byte field by field and the erase opcode.
  task automatic caps_scn();
    logic [33:0] got;
    fetch(12'h0C0, got);
    check(got, {2'h0, 32'h0000_00FD});
    check(34'(got[1:0]), 34'h1);
    check(34'(got[2]), 34'h1);
    check(34'(got[3]), 34'h1);
    check(34'(got[4]), 34'h1);
    check(34'(got[7:5]), 34'h7);
    fetch(12'h0C4, got);
    check(got, {2'h0, 32'h0000_0020});
  endtask : caps_scn

  // Table writes, unmapped, unaligned and empty places are refused.
  task automatic refuse_scn();
    logic [33:0] got;
    put(12'h0C0, 32'h0000_0000, 4'hF, got);
    check(got, {2'h2, 32'h0000_0000});
    fetch(12'h0C0, got);
    check(got, {2'h0, 32'h0000_00FD});
    put(12'h04C, 32'h0000_0000, 4'hF, got);
    check(got, {2'h2, 32'h0000_0000});
    fetch(12'h04C, got);
    check(got, {2'h0, 32'h0000_0006});
    fetch(12'h800, got);
    check(got, {2'h2, 32'h0000_0000});
    fetch(12'h04D, got);
    check(got, {2'h2, 32'h0000_0000});
    fetch(12'h080, got);
    check(got, {2'h2, 32'h0000_0000});
  endtask : refuse_scn

  // Streams successive bytes from a loaded cursor, past byte 1FH into an unmapped byte.
  task automatic stream_scn();
    logic [8:0] seq [0:4] = '{9'h100, 9'h102, 9'h100, 9'h101, 9'h0FF};
    logic [33:0] got;
    put(12'h400, 32'h0000_001C, 4'hF, got);
    check(got, 34'h0);
    for (int i = 0; i < 5; i++) begin
      fetch(12'h404, got);
      check(got, {2'h0, 23'h00_0000, seq[i]});
    end
    fetch(12'h400, got);
    check(got, {2'h0, 32'h0000_0021});
    put(12'h400, 32'hFFFF_FF30, 4'h1, got);
    check(got, 34'h0);
    fetch(12'h404, got);
    check(got, {2'h0, 32'h0000_01FD});
    fetch(12'h404, got);
    check(got, {2'h0, 32'h0000_0120});
    fetch(12'h400, got);
    check(got, {2'h0, 32'h0000_0032});
  endtask : stream_scn

  // Resets in mid-run; the bus comes back idle and the cursor at zero.
  task automatic reset_scn();
    logic [33:0] got;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({29'h0, awready, wready, arready, bvalid, rvalid}, 34'h1C);
    fetch(12'h400, got);
    check(got, 34'h0);
    fetch(12'h04C, got);
    check(got, {2'h0, 32'h0000_0006});
  endtask : reset_scn

  // Free-running bus clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Watchdog that cuts a stuck run short.
  initial begin
    repeat (100000) @(posedge aclk);
    errors++;
    $display("BAD %0t run limit reached", $time);
    end_sim();
  end

  // Reset, then every scenario in turn.
  initial begin
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    headers_scn();
    caps_scn();
    refuse_scn();
    stream_scn();
    reset_scn();
    end_sim();
  end
endmodule : test_param_rom_slice
